//--- hdl/ascr_consts.svh
/*
 * Constants of the serial configuration register bank: register offsets,
 * field positions, reset values, frame layout and the power-control key.
 * Assumes it is included by bare name from the package and the bench.
 */
`ifndef ASCR_CONSTS_SVH
`define ASCR_CONSTS_SVH

// register offsets (9-bit address space)
`define ASCR_ADDR_W           9
`define ASCR_OFS_PWR          9'h010
`define ASCR_OFS_KEY          9'h011
`define ASCR_OFS_WRP          9'h014
`define ASCR_OFS_RDP          9'h018
`define ASCR_OFS_OWC          9'h01C
`define ASCR_KEY_VALUE        8'h69

// frame layout of the 20-bit shift register
`define ASCR_WORD_W           20
`define ASCR_CMD_W            3
`define ASCR_CMD_WRITE        3'h5
`define ASCR_CMD_READ         3'h2

// field positions
`define ASCR_PWR_SLEEP_BIT    1
`define ASCR_PWR_DOWN_BIT     0
`define ASCR_RDP_BIT5         5
`define ASCR_RDP_RATE_BIT     4

// reset values
`define ASCR_PWR_RST          2'h0
`define ASCR_WRP_RST          2'h0
`define ASCR_RDP_RST          8'h00
`define ASCR_OWC_RST          6'h00

`endif

//--- hdl/ascr_pkg.sv
/*
 * Types of the serial configuration register bank.
 * Assumes ascr_consts.svh is on the include path.
 */
`include "ascr_consts.svh"

package ascr_pkg;

    // frame command codes
    typedef enum logic [`ASCR_CMD_W-1:0]
    {
        ASCR_CMD_NOP   = 3'h0,
        ASCR_CMD_RD    = `ASCR_CMD_READ,
        ASCR_CMD_WR    = `ASCR_CMD_WRITE
    } ascr_cmd_e;

    // decoded 20-bit command frame
    typedef struct packed
    {
        logic [`ASCR_CMD_W-1:0]  cmd;
        logic [`ASCR_ADDR_W-1:0] addr;
        logic [7:0]              data;
    } ascr_frame_s;

    // serial pins from the host
    typedef struct packed
    {
        logic cs_n;
        logic sclk;
        logic sdi;
    } ascr_serial_in_s;

    // output lanes with their enables
    typedef struct packed
    {
        logic [3:0] oe;
        logic [3:0] dat;
    } ascr_lanes_s;

endpackage

//--- hdl/ascr_regbank.sv
/*
 * Serial configuration register bank of a sampling converter: 20-bit
 * unified shift register, frame decode on chip-select rise, keyed power
 * control, write/read protocol and output word control registers, and
 * the lane driver for SPI-follow and source-synchronous output.
 * Assumes serial pins are synchronous to clk (40 MHz) and that the host
 * keeps its own framing duties.
 */
// Notes on behaviour
// R1 - host sends 20 x N edges per chain
// R2 - longer chain frames need host-aligned bits
// R3 - host never sends short chain frames
// R4 - star host selects one device only
// R5 - four registers at 010h,014h,018h,01Ch
// R6 - power write needs 69h key at 011h
// R7 - bit 1 enables light sleep, reset 0
// R8 - bit 0 powers down, reset 0
// R9 - bits 7:2 of two registers read zero
// R10 - two-bit write mode picks CPOL/CPHASE
// R11 - clock select acts only in mode 11b
// R12 - read protocol bit 5 reads zero
// R13 - rate bit: single or double in mode 11b
// R14 - lane width field picks 1, 2, 4 lanes
// R15 - protocol mode: 00b follow SPI, 11b sync
// R16 - fourth register shapes the output word
// R17 - mode 00h merges into one shift register
// R18 - double rate: strobe and bits each edge
// R19 - lanes released while chip select high
`timescale 1ns/10ps
`default_nettype none

module ascr_regbank
    import ascr_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // serial pins from the host
    input  wire ascr_pkg::ascr_serial_in_s pins,
    // conversion result to ship out
    input  wire logic [15:0]            conv_data,
    // output lanes, strobe and clock
    output var  ascr_pkg::ascr_lanes_s  lanes,
    output logic                        ready_strobe,
    output logic                        sync_clk_out,
    // power controls to the analog core
    output logic                        power_down,
    output logic                        light_sleep_enable,
    // output word control to the data formatter
    output logic [5:0]                  output_word_ctrl
);
    import ascr_pkg::*;

    logic [1:0]              pwr_reg;
    logic [1:0]              wrp_reg;
    logic [7:0]              rdp_reg;
    logic [5:0]              owc_reg;
    logic                    key_armed_reg;
    logic [`ASCR_WORD_W-1:0] usr_reg;
    logic [`ASCR_WORD_W-1:0] osh_reg;
    logic [3:0]              lane_dat_reg;
    logic [3:0]              lane_oe_reg;
    logic [`ASCR_WORD_W-1:0] next_word_reg;
    logic                    rd_pend_reg;
    logic                    sclk_q_reg;
    logic                    cs_q_reg;
    logic [1:0]              div_reg;
    logic [4:0]              left_reg;
    logic [7:0]              rd_data;
    logic [3:0]              width_mask;
    logic [2:0]              step;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    cs_fall;
    logic                    cs_rise;
    logic                    capture;
    logic                    launch;
    logic                    sync_mode;
    logic                    div_tick;
    logic                    sync_tick;
    logic                    sync_launch;
    ascr_frame_s             frame;

    // edge detection on the sampled pins
    assign sclk_rise = pins.sclk & ~sclk_q_reg;
    assign sclk_fall = ~pins.sclk & sclk_q_reg;
    assign cs_fall   = ~pins.cs_n & cs_q_reg;
    assign cs_rise   = pins.cs_n & ~cs_q_reg;
    assign frame     = ascr_frame_s'(usr_reg);
    // lane data and enables come from separate flip-flop groups
    assign lanes     = '{oe: lane_oe_reg, dat: lane_dat_reg};

    // capture edge is rising when CPOL equals CPHASE, launch the other
    assign capture   = (wrp_reg[1] == wrp_reg[0]) ? sclk_rise : sclk_fall; // [R10]
    assign launch    = (wrp_reg[1] == wrp_reg[0]) ? sclk_fall : sclk_rise;
    assign sync_mode = (rdp_reg[1:0] == 2'h3); // [R15]

    // lane count from the width field
    always_comb
    begin
        case (rdp_reg[3:2]) // [R14]
            2'h2:    begin width_mask = 4'h3; step = 3'h2; end
            2'h3:    begin width_mask = 4'hF; step = 3'h4; end
            default: begin width_mask = 4'h1; step = 3'h1; end
        endcase
    end

    // divider of the internal clock for the sync output clock
    assign div_tick = (rdp_reg[7:6] == 2'h1) ||
                      (rdp_reg[7:6] == 2'h2 && div_reg[0]) ||
                      (rdp_reg[7:6] == 2'h3 && div_reg == 2'h3);
    // echoed sclk or divided internal clock; select only counts in 11b
    assign sync_tick   = sync_mode && !pins.cs_n && left_reg != 5'h0 &&
                         ((rdp_reg[7:6] == 2'h0) ? (sclk_rise | sclk_fall)
                                                 : div_tick); // [R11]
    // single rate launches on rising strobe only, double rate on both
    assign sync_launch = sync_tick && (rdp_reg[`ASCR_RDP_RATE_BIT] || !ready_strobe); // [R13] [R18]

    // register read mux; reserved bits return zero
    always_comb
    begin
        case (frame.addr)
            `ASCR_OFS_PWR: rd_data = {6'h00, pwr_reg}; // [R9]
            `ASCR_OFS_WRP: rd_data = {6'h00, wrp_reg}; // [R9]
            `ASCR_OFS_RDP: rd_data = rdp_reg;
            `ASCR_OFS_OWC: rd_data = {2'h0, owc_reg};
            default:       rd_data = 8'h00;
        endcase
    end

    // pin history for edge detection and the sync clock divider
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q_reg <= 1'b0;
            cs_q_reg   <= 1'b1;
            div_reg    <= 2'h0;
        end
        else
        begin
            sclk_q_reg <= pins.sclk;
            cs_q_reg   <= pins.cs_n;
            div_reg    <= pins.cs_n ? 2'h0 : div_reg + 2'h1;
        end
    end

    // unified shift register: loaded at frame start, shifts sdi in
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            usr_reg <= '0;
        else if (cs_fall)
            usr_reg <= next_word_reg;
        else if (!pins.cs_n && capture)
            usr_reg <= {usr_reg[`ASCR_WORD_W-2:0], pins.sdi}; // [R17]
    end

    // frame decode on chip-select rise: register writes and the key
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_reg       <= `ASCR_PWR_RST; // [R7] [R8]
            wrp_reg       <= `ASCR_WRP_RST;
            rdp_reg       <= `ASCR_RDP_RST;
            owc_reg       <= `ASCR_OWC_RST;
            key_armed_reg <= 1'b0;
        end
        else if (cs_rise)
        begin
            key_armed_reg <= (frame.cmd == ASCR_CMD_WR &&
                              frame.addr == `ASCR_OFS_KEY &&
                              frame.data == `ASCR_KEY_VALUE); // [R6]
            if (frame.cmd == ASCR_CMD_WR)
            begin
                case (frame.addr) // [R5]
                    `ASCR_OFS_PWR:
                        if (key_armed_reg)
                            pwr_reg <= frame.data[1:0]; // [R6] [R7] [R8]
                    `ASCR_OFS_WRP: wrp_reg <= frame.data[1:0]; // [R10]
                    `ASCR_OFS_RDP: rdp_reg <= {frame.data[7:6], 1'b0,
                                               frame.data[4:0]}; // [R12]
                    `ASCR_OFS_OWC: owc_reg <= frame.data[5:0]; // [R16]
                    default:       ;
                endcase
            end
        end
    end

    // word for the next frame: read answer or conversion result
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            next_word_reg <= '0;
            rd_pend_reg   <= 1'b0;
        end
        else if (cs_rise && frame.cmd == ASCR_CMD_RD)
        begin
            next_word_reg <= {rd_data, 12'h000};
            rd_pend_reg   <= 1'b1;
        end
        else if (cs_fall)
            rd_pend_reg   <= 1'b0;
        else if (!rd_pend_reg)
            next_word_reg <= {conv_data, 4'h0};
    end

    // output shift, strobe and sync clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osh_reg      <= '0;
            left_reg     <= 5'h0;
            lane_dat_reg <= 4'h0;
            ready_strobe <= 1'b0;
            sync_clk_out <= 1'b0;
        end
        else if (cs_fall)
        begin
            // spi-follow: the msb must stand before the first capture edge
            osh_reg      <= next_word_reg;
            left_reg     <= 5'(`ASCR_WORD_W);
            lane_dat_reg <= {3'h0, next_word_reg[`ASCR_WORD_W-1] & ~sync_mode}; // [R17]
            ready_strobe <= 1'b0;
            sync_clk_out <= 1'b0;
        end
        else if (!pins.cs_n && !sync_mode && launch)
        begin
            // follow the input SPI mode; lane 0 is the merged register
            lane_dat_reg <= {osh_reg[`ASCR_WORD_W-2 -: 3] & width_mask[3:1],
                             usr_reg[`ASCR_WORD_W-1]}; // [R15] [R17]
            osh_reg      <= osh_reg << step;
        end
        else if (sync_tick)
        begin
            ready_strobe <= ~ready_strobe; // [R18]
            sync_clk_out <= ~sync_clk_out;
            if (sync_launch)
            begin
                lane_dat_reg <= osh_reg[`ASCR_WORD_W-1 -: 4] & width_mask; // [R14]
                osh_reg   <= osh_reg << step;
                left_reg  <= (left_reg > 5'(step)) ? left_reg - 5'(step) : 5'h0;
            end
        end
    end

    // lanes released while deselected so star devices share a line
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lane_oe_reg <= 4'h0;
        else
            lane_oe_reg <= pins.cs_n ? 4'h0 : width_mask; // [R19] [R4]
    end

    // power controls and output word control driven out
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_down         <= 1'b0;
            light_sleep_enable <= 1'b0;
            output_word_ctrl   <= `ASCR_OWC_RST;
        end
        else
        begin
            power_down         <= pwr_reg[`ASCR_PWR_DOWN_BIT]; // [R8]
            light_sleep_enable <= pwr_reg[`ASCR_PWR_SLEEP_BIT]; // [R7]
            output_word_ctrl   <= owc_reg; // [R16]
        end
    end

    // checks on the logic above
    a_key_gate_pwr: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        cs_rise && frame.cmd == ASCR_CMD_WR && frame.addr == `ASCR_OFS_PWR && !key_armed_reg
        |=> $stable(pwr_reg))
        else $error("power control changed without key");
    a_key_arm_seq: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        cs_rise && frame.cmd == ASCR_CMD_WR && frame.addr == `ASCR_OFS_KEY &&
        frame.data == `ASCR_KEY_VALUE |=> key_armed_reg)
        else $error("key write did not arm");
    a_pwr_to_pins: assert property (@(posedge clk) disable iff (!rst_n) // [R7] [R8]
        ##1 power_down == $past(pwr_reg[0]) && light_sleep_enable == $past(pwr_reg[1]))
        else $error("power pins do not follow register");
    a_rdp_bit5_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        cs_rise && frame.cmd == ASCR_CMD_WR && frame.addr == `ASCR_OFS_RDP
        |=> rdp_reg[`ASCR_RDP_BIT5] == 1'b0 && rdp_reg[4:0] == $past(frame.data[4:0]))
        else $error("read protocol bit 5 not zero");
    a_reserved_read: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        (frame.addr == `ASCR_OFS_PWR || frame.addr == `ASCR_OFS_WRP) |-> rd_data[7:2] == 6'h00)
        else $error("reserved bits read nonzero");
    a_wrp_update: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        cs_rise && frame.cmd == ASCR_CMD_WR && frame.addr == `ASCR_OFS_WRP
        |=> wrp_reg == $past(frame.data[1:0]))
        else $error("write mode not updated");
    a_lanes_release: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
        pins.cs_n |=> lanes.oe == 4'h0)
        else $error("lanes driven while deselected");
    a_lane_width: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        !pins.cs_n |=> lanes.oe == $past(width_mask))
        else $error("lane enables disagree with width");
    a_strobe_tick: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        sync_tick && !cs_fall |=> ready_strobe != $past(ready_strobe) &&
        sync_clk_out != $past(sync_clk_out))
        else $error("strobe missed an output clock edge");
    a_follow_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        !sync_mode && !cs_fall |=> $stable(ready_strobe))
        else $error("strobe moved outside sync mode");

endmodule

`default_nettype wire

//--- verification/adc_serial_config_registers_bench.sv
/*
 * Self-checking bench of the register bank, driven through the host model.
 * Assumes ascr_consts.svh is on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ascr_consts.svh"

module adc_serial_config_registers_bench;
    import ascr_pkg::*;

    localparam logic [8:0] PWR = `ASCR_OFS_PWR;
    localparam logic [8:0] KEY = `ASCR_OFS_KEY;
    localparam logic [8:0] WRP = `ASCR_OFS_WRP;
    localparam logic [8:0] RDP = `ASCR_OFS_RDP;
    localparam logic [8:0] OWC = `ASCR_OFS_OWC;

    logic            clk;
    logic            rst_n;
    ascr_serial_in_s pins;
    logic [15:0]     conv_data;
    ascr_lanes_s     lanes;
    logic            ready_strobe;
    logic            sync_clk_out;
    logic            power_down;
    logic            light_sleep_enable;
    logic [5:0]      output_word_ctrl;
    int              bad_count;
    int              n_checks;
    int              cyc;
    logic [19:0]     rx;
    logic [7:0]      rv;
    logic [7:0]      d;
    logic [8:0]      addrs [5] = '{PWR, WRP, RDP, OWC, 9'h012};

    ascr_regbank ascr_regbank_i (.clk(clk), .rst_n(rst_n), .pins(pins), .conv_data(conv_data),
        .lanes(lanes), .ready_strobe(ready_strobe), .sync_clk_out(sync_clk_out),
        .power_down(power_down), .light_sleep_enable(light_sleep_enable),
        .output_word_ctrl(output_word_ctrl));
    ascr_host_model ascr_host_model_i (.clk(clk), .pins(pins), .lanes(lanes));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    // readback value after the read-only bits
    function automatic logic [7:0] exp_reg(input logic [8:0] a, input logic [7:0] v);
        case (a)
            PWR, WRP: return v & 8'h03;
            RDP:      return v & 8'hDF;
            OWC:      return v & 8'h3F;
            default:  return 8'h00;
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(input logic [1:0] w);
        return w[1] ? (w[0] ? 4'hF : 4'h3) : 4'h1;
    endfunction

    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic compare_word(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        ascr_host_model_i.frame({`ASCR_CMD_WRITE, a, v}, rx);
    endtask

    // read frame, then a no-op frame that carries the answer
    task automatic expect_reg(input logic [8:0] a, input logic [7:0] exp);
        ascr_host_model_i.frame({`ASCR_CMD_READ, a, 8'h00}, rx);
        ascr_host_model_i.frame(20'h00000, rx);
        compare(rx[19:12], exp);
    endtask

    // clocks between the 1st and 2nd toggle after the frame start clears it
    task automatic measure(output logic [7:0] per);
        logic last;
        int   n;
        int   cnt;
        per = 8'hFF;
        n = 0;
        cnt = 0;
        repeat (2) @(negedge clk);
        last = sync_clk_out;
        for (int k = 0; k < 30 && n < 2; k++)
        begin
            @(negedge clk);
            cnt++;
            if (sync_clk_out !== last)
            begin
                last = sync_clk_out;
                if (n == 1)
                    per = 8'(cnt);
                n++;
                cnt = 0;
            end
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        conv_data = 16'h0000;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        rv = 8'($urandom(32'h7909));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        compare({4'h0, lanes.oe}, 8'h00);
        foreach (addrs[k])
            expect_reg(addrs[k], 8'h00);
        wr(PWR, 8'hFF);
        expect_reg(PWR, 8'h00);
        wr(KEY, `ASCR_KEY_VALUE);
        wr(PWR, 8'hFF);
        expect_reg(PWR, exp_reg(PWR, 8'hFF));
        compare({6'h0, light_sleep_enable, power_down}, 8'h03);
        wr(KEY, 8'h68);
        wr(PWR, 8'h00);
        wr(KEY, `ASCR_KEY_VALUE);
        wr(OWC, 8'h00);
        wr(PWR, 8'h00);
        expect_reg(PWR, 8'h03);
        wr(KEY, `ASCR_KEY_VALUE);
        wr(PWR, 8'h02);
        compare({6'h0, light_sleep_enable, power_down}, 8'h02);
        wr(WRP, 8'hFC);
        expect_reg(WRP, 8'h00);
        wr(RDP, 8'h21);
        expect_reg(RDP, 8'h01);
        repeat (8)
        begin
            d = 8'($urandom);
            conv_data = 16'($urandom);
            wr(OWC, d);
            compare_word(rx, {conv_data, 4'h0});
            expect_reg(OWC, exp_reg(OWC, d));
            compare({2'h0, output_word_ctrl}, exp_reg(OWC, d));
        end
        for (int w = 0; w < 4; w++)
        begin
            wr(RDP, {4'h1, 2'(w), 2'h0});
            expect_reg(RDP, {4'h1, 2'(w), 2'h0});
            compare({4'h0, ascr_host_model_i.oe_mid}, {4'h0, lane_mask(2'(w))});
        end
        for (int m = 1; m < 4; m++)
        begin
            wr(WRP, 8'(m));
            ascr_host_model_i.spi_mode = 2'(m);
            wr(OWC, 8'(8 + m));
            wr(WRP, 8'h00);
            ascr_host_model_i.spi_mode = 2'h0;
            compare({2'h0, output_word_ctrl}, exp_reg(OWC, 8'(8 + m)));
        end
        // the clockless sync frames decode a no-op word
        conv_data = 16'h0000;
        for (int s = 1; s < 4; s++)
        begin
            wr(RDP, {2'(s), 6'h03});
            fork
                ascr_host_model_i.hold_select(40);
                measure(rv);
            join
            compare(rv, 8'(1 << (s - 1)));
        end
        wr(RDP, 8'h00);
        compare({6'h0, ready_strobe, lanes.oe[0]}, 8'h00);
        end_of_test();
    end
endmodule

`default_nettype wire

//--- verification/ascr_host_model.sv
/*
 * Host controller model: sends 20-bit command frames in any SPI mode.
 * Assumes one device on the lines and a 40 MHz clk to pace the pins.
 */
`timescale 1ns/10ps
`default_nettype none

module ascr_host_model
(
    // clock
    input  wire logic                      clk,
    // serial pins to the device
    output var  ascr_pkg::ascr_serial_in_s pins,
    // lanes from the device
    input  wire ascr_pkg::ascr_lanes_s     lanes
);
    import ascr_pkg::*;

    logic [1:0] spi_mode;   // cpol, cpha in use
    logic [3:0] oe_mid;     // lane enables seen mid-frame

    // pins idle, device deselected
    initial
    begin
        pins = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
        spi_mode = 2'h0;
        oe_mid = 4'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one frame msb first; rx takes lane 0 just before each capture edge
    task automatic frame(input logic [19:0] tx, output logic [19:0] rx);
        wait_clk(1);
        pins.sclk = spi_mode[1];
        wait_clk(1);
        pins.cs_n = 1'b0;
        wait_clk(2);
        for (int i = 19; i >= 0; i--)
        begin
            if (spi_mode[0])
                pins.sclk = ~spi_mode[1];
            pins.sdi = tx[i];
            wait_clk(2);
            rx[i] = lanes.oe[0] ? lanes.dat[0] : ~lanes.dat[0]; // released line reads inverted
            if (i == 10)
                oe_mid = lanes.oe;
            pins.sclk = ~pins.sclk;
            wait_clk(2);
            if (!spi_mode[0])
            begin
                pins.sclk = spi_mode[1];
                wait_clk(2);
            end
        end
        pins.cs_n = 1'b1;
        pins.sdi = ~pins.sdi; // released line shows no stale bit
        wait_clk(3);
    endtask

    // select the device with no clocking, for sync output clocks
    task automatic hold_select(input int n);
        wait_clk(1);
        pins.cs_n = 1'b0;
        wait_clk(n);
        pins.cs_n = 1'b1;
        wait_clk(3);
    endtask
endmodule

`default_nettype wire
